/* File: rtl/rss_reset_sequencer.sv */
// Purpose: Gathers all reset sources into one device reset and records the cause.
// Assumes: Supply monitor and pin inputs are asynchronous; core strobes share clock_i.
// Notes: Cause flags reload only on reset_n_i, power-on or programming exit; a brown-out rewrites all but RI and POR, other device resets wipe none.

// Filter that asserts only after its input was active for LIMIT + 1 cycles in a row.
module rss_glitch_filter #(
    parameter int unsigned LIMIT = 1
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic active_i,
    output logic level_o
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    logic [CW-1:0] cnt_r;

    initial begin
        if (LIMIT < 1) $error("filter limit must be at least one");
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
        end else if (!active_i) begin
            cnt_r <= '0;
        end else if (cnt_r != CW'(LIMIT)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_o <= 1'b0;
        end else begin
            level_o <= active_i && (cnt_r == CW'(LIMIT));
        end
    end
endmodule

module rss_reset_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_CYCLES,
    parameter int unsigned BOR_FLT_CYC = BOR_FILTER_CYCLES,
    parameter int unsigned PIN_FLT_CYC = PIN_FILTER_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [1:0] brownout_mode_sel_i,
    input wire logic powerup_delay_disable_n_i,
    input wire logic ext_reset_pin_enable_i,
    input wire logic low_voltage_prog_enable_i,
    input wire logic lowpower_brownout_disable_i,
    input wire logic stack_fault_reset_enable_i,
    input wire logic por_active_i,
    input wire logic bor_below_i,
    input wire logic bor_ready_i,
    input wire logic lowpower_brownout_below_i,
    input wire logic osc_ready_i,
    input wire logic external_reset_pin_i,
    input wire logic sleep_i,
    input wire logic watchdog_timeout_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic reset_instr_i,
    input wire logic stack_over_i,
    input wire logic stack_under_i,
    input wire logic prog_exit_i,
    output logic core_reset_o,
    output logic wake_hold_o,
    output logic bor_monitor_en_o,
    output logic bandgap_force_o,
    output logic pin_pullup_en_o,
    output logic pin_out_o,
    output logic pin_oe_n_o,
    output logic pin_gpio_level_o
);
    localparam int unsigned CNT_MAX = (POWERUP_DELAY_TIMER_CYC > EXEC_DELAY_CYCLES) ?
        POWERUP_DELAY_TIMER_CYC : EXEC_DELAY_CYCLES;
    localparam int unsigned CW = $clog2(CNT_MAX + 1);

    initial begin
        if (POWERUP_DELAY_TIMER_CYC < 1 || BOR_FLT_CYC < 1 || PIN_FLT_CYC < 1)
            $error("cycle counts must be at least one");
    end

    // Two-flop synchronisers for the asynchronous monitor and pin inputs.
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_r <= 6'h3f;
            sync2_r <= 6'h3f;
        end else begin
            sync1_r <= {por_active_i, bor_below_i, bor_ready_i, lowpower_brownout_below_i,
                        osc_ready_i, external_reset_pin_i};
            sync2_r <= sync1_r;
        end
    end
    logic por_s, bor_below_s, bor_ready_s, lowpower_brownout_below_s, osc_ready_s, pin_s;
    assign {por_s, bor_below_s, bor_ready_s, lowpower_brownout_below_s, osc_ready_s, pin_s} = sync2_r;

    logic sbor_en_r, brownout_fast_start_r, pullup_sw_r;
    logic [7:0] power_control_reg_r;
    logic to_n_r, pd_n_r;
    rss_state_t st_r, st_nxt;
    logic [CW-1:0] cnt_r;
    logic pin_low_d_r, sleep_d_r;

    // Monitor enable by mode.
    logic mon_en, mon_ready, start_ok;
    always_comb begin
        case (brownout_mode_sel_i)
            BOR_ALWAYS_ON: mon_en = 1'b1;
            BOR_NO_SLEEP: mon_en = !sleep_i;
            BOR_SOFTWARE: mon_en = sbor_en_r;
            default: mon_en = 1'b0;
        endcase
    end
    // Mode 00 leaves ready undefined; it reads as 0 here.
    assign mon_ready = mon_en && bor_ready_s;
    // Modes 11 and 10 hold start-up until monitor ready and supply good.
    assign start_ok = !brownout_mode_sel_i[1] || (bor_ready_s && !bor_below_s);

    logic bor_flt, pin_flt;
    rss_glitch_filter #(.LIMIT(BOR_FLT_CYC)) u_bor_flt (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .active_i(mon_ready && bor_below_s),
        .level_o(bor_flt)
    );

    logic pin_en;
    assign pin_en = low_voltage_prog_enable_i || ext_reset_pin_enable_i;
    rss_glitch_filter #(.LIMIT(PIN_FLT_CYC)) u_pin_flt (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .active_i(!pin_s),
        .level_o(pin_flt)
    );

    logic lowpower_brownout_act, bor_any, pin_low, power_evt, wdt_evt, stk_ovf, stk_unf;
    logic soft_evt, pin_evt, sleep_entry;
    assign lowpower_brownout_act = !lowpower_brownout_disable_i && lowpower_brownout_below_s;
    assign bor_any = bor_flt || lowpower_brownout_act;
    assign pin_low = pin_en && pin_flt;
    assign power_evt = por_s || bor_any || prog_exit_i;
    assign wdt_evt = watchdog_timeout_i;
    assign stk_ovf = stack_fault_reset_enable_i && stack_over_i;
    assign stk_unf = stack_fault_reset_enable_i && stack_under_i;
    assign soft_evt = wdt_evt || reset_instr_i || stk_ovf || stk_unf;
    assign pin_evt = pin_low && !pin_low_d_r;
    assign sleep_entry = sleep_i && !sleep_d_r;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_low_d_r <= 1'b0;
            sleep_d_r <= 1'b0;
        end else begin
            pin_low_d_r <= pin_low;
            sleep_d_r <= sleep_i;
        end
    end

    // Start-up sequence.
    always_comb begin
        st_nxt = st_r;
        if (power_evt) begin
            st_nxt = ST_HOLD;
        end else begin
            case (st_r)
                ST_HOLD: st_nxt = powerup_delay_disable_n_i ? ST_START : ST_POWERUP_DELAY_TIMER;
                ST_POWERUP_DELAY_TIMER: if (cnt_r == '0) st_nxt = ST_START;
                ST_START: if (osc_ready_s && !pin_low && start_ok) st_nxt = ST_EXEC;
                ST_EXEC: begin
                    if (soft_evt || pin_low) st_nxt = ST_START;
                    else if (cnt_r == '0) st_nxt = ST_RUN;
                end
                ST_RUN: if (soft_evt || pin_low) st_nxt = ST_START;
                default: st_nxt = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= ST_HOLD;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Shared down-counter for the power-up delay and the execution delay.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
        end else if (st_r == ST_HOLD) begin
            cnt_r <= CW'(POWERUP_DELAY_TIMER_CYC - 1);
        end else if (st_r == ST_START) begin
            cnt_r <= CW'(EXEC_DELAY_CYCLES - 1);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Reset leaves on one clock edge, derived from the next state st_nxt.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_reset_o <= 1'b1;
        end else begin
            core_reset_o <= (st_nxt != ST_RUN);
        end
    end

    // Mode 10 stalls the core after Sleep until the monitor is ready again.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_hold_o <= 1'b0;
        end else begin
            wake_hold_o <= (brownout_mode_sel_i == BOR_NO_SLEEP) && !sleep_i
                && !bor_ready_s;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bor_monitor_en_o <= 1'b0;
            bandgap_force_o <= 1'b0;
        end else begin
            bor_monitor_en_o <= mon_en;
            bandgap_force_o <= brownout_fast_start_r && (brownout_mode_sel_i == BOR_NO_SLEEP
                || brownout_mode_sel_i == BOR_SOFTWARE);
        end
    end

    // Pin driver stays released; only pull-up and input level are used.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_out_o <= 1'b1;
            pin_oe_n_o <= 1'b1;
            pin_pullup_en_o <= 1'b1;
            pin_gpio_level_o <= 1'b1;
        end else begin
            pin_out_o <= 1'b1;
            pin_oe_n_o <= 1'b1;
            pin_pullup_en_o <= pin_en || pullup_sw_r;
            pin_gpio_level_o <= pin_s;
        end
    end

    logic wr_brownout_control, wr_power_control_reg, wr_pinctl;
    assign wr_brownout_control = reg_wr_i && (reg_addr_i == REG_BROWNOUT_CONTROL);
    assign wr_power_control_reg = reg_wr_i && (reg_addr_i == REG_POWER_CONTROL_REG);
    assign wr_pinctl = reg_wr_i && (reg_addr_i == REG_PINCTL);

    // Brown-out control bits; restored on power events.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sbor_en_r <= BROWNOUT_CONTROL_SBOR_RST;
            brownout_fast_start_r <= BROWNOUT_CONTROL_FS_RST;
        end else if (power_evt) begin
            sbor_en_r <= BROWNOUT_CONTROL_SBOR_RST;
            brownout_fast_start_r <= BROWNOUT_CONTROL_FS_RST;
        end else if (wr_brownout_control) begin
            sbor_en_r <= reg_wdata_i[BROWNOUT_CONTROL_SBOR_BIT];
            brownout_fast_start_r <= reg_wdata_i[BROWNOUT_CONTROL_FS_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pullup_sw_r <= PINCTL_PULLUP_RST;
        end else if (wr_pinctl) begin
            pullup_sw_r <= reg_wdata_i[PINCTL_PULLUP_BIT];
        end
    end

    // Reset cause flags; a hardware event wins over a write in the same cycle.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_control_reg_r <= POWER_CONTROL_REG_POR_VAL;
        end else if (por_s || prog_exit_i) begin
            power_control_reg_r <= POWER_CONTROL_REG_POR_VAL;
        end else begin
            if (wr_power_control_reg) power_control_reg_r <= reg_wdata_i & POWER_CONTROL_REG_IMPL_MASK;
            if (bor_any) begin
                power_control_reg_r[POWER_CONTROL_REG_OVF_BIT] <= 1'b0;
                power_control_reg_r[POWER_CONTROL_REG_UNF_BIT] <= 1'b0;
                power_control_reg_r[POWER_CONTROL_REG_WDT_BIT] <= 1'b1;
                power_control_reg_r[POWER_CONTROL_REG_PIN_BIT] <= 1'b1;
                power_control_reg_r[POWER_CONTROL_REG_BOR_BIT] <= 1'b0;
            end else begin
                if (wdt_evt) power_control_reg_r[POWER_CONTROL_REG_WDT_BIT] <= 1'b0;
                if (pin_evt) power_control_reg_r[POWER_CONTROL_REG_PIN_BIT] <= 1'b0;
                if (reset_instr_i) power_control_reg_r[POWER_CONTROL_REG_RI_BIT] <= 1'b0;
                if (stk_ovf) power_control_reg_r[POWER_CONTROL_REG_OVF_BIT] <= 1'b1;
                if (stk_unf) power_control_reg_r[POWER_CONTROL_REG_UNF_BIT] <= 1'b1;
            end
        end
    end

    // Timeout and powerdown status bits.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end else if (power_evt) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end else if (wdt_evt) begin
            to_n_r <= 1'b0;
            pd_n_r <= pd_n_r && !sleep_i;
        end else if (pin_evt && sleep_i) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b0;
        end else if (watchdog_clear_instr_i) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end else if (sleep_entry) begin
            to_n_r <= 1'b1;
            pd_n_r <= 1'b0;
        end
    end

    // Read data stand for the one cycle after the read strobe.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr_i)
            REG_BROWNOUT_CONTROL: begin
                rd_mux[BROWNOUT_CONTROL_SBOR_BIT] = sbor_en_r;
                rd_mux[BROWNOUT_CONTROL_FS_BIT] = brownout_fast_start_r;
                rd_mux[BROWNOUT_CONTROL_RDY_BIT] = mon_ready;
            end
            REG_POWER_CONTROL_REG: rd_mux = power_control_reg_r;
            REG_STATUS: begin
                rd_mux[STATUS_TO_BIT] = to_n_r;
                rd_mux[STATUS_PD_BIT] = pd_n_r;
            end
            REG_PINCTL: begin
                rd_mux[PINCTL_PULLUP_BIT] = pullup_sw_r;
                rd_mux[PINCTL_LEVEL_BIT] = pin_s;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    powerup_delay_timer_hold_a: assert property (st_r == ST_POWERUP_DELAY_TIMER |=> core_reset_o)
        else $error("reset released during power-up delay");
    powerup_delay_timer_skip_a: assert property (st_r == ST_HOLD && !power_evt
        && powerup_delay_disable_n_i |=> st_r == ST_START)
        else $error("power-up delay not skipped");
    powerup_delay_timer_start_a: assert property ($rose(st_r == ST_POWERUP_DELAY_TIMER) |-> $past(!power_evt))
        else $error("power-up delay began during power event");
    mode_on_a: assert property (brownout_mode_sel_i == BOR_ALWAYS_ON
        |=> bor_monitor_en_o)
        else $error("monitor off in always-on mode");
    mode_off_a: assert property (brownout_mode_sel_i == BOR_ALWAYS_OFF
        |=> !bor_monitor_en_o && reg_rdata_o[BROWNOUT_CONTROL_RDY_BIT] == 1'b0)
        else $error("monitor active in off mode");
    bor_filter_a: assert property (bor_flt |-> $past(bor_below_s, BOR_FLT_CYC))
        else $error("brown-out without long enough dip");
    pin_release_a: assert property (pin_oe_n_o && pin_out_o)
        else $error("reset pin driven");
    ri_flag_a: assert property (reset_instr_i && !power_evt
        |=> !power_control_reg_r[POWER_CONTROL_REG_RI_BIT] ##1 core_reset_o)
        else $error("reset instruction flag not cleared");
    lowpower_brownout_flag_a: assert property (lowpower_brownout_act && !por_s && !prog_exit_i
        |=> !power_control_reg_r[POWER_CONTROL_REG_BOR_BIT])
        else $error("low-power brown-out flag not recorded");
    exec_delay_a: assert property ($fell(core_reset_o) |->
        $past(st_r == ST_EXEC) && $past(osc_ready_s, EXEC_DELAY_CYCLES + 1))
        else $error("execution began without delay");

    run_cov_c: cover property ($fell(core_reset_o));
    powerup_delay_timer_cov_c: cover property (st_r == ST_POWERUP_DELAY_TIMER ##1 st_r == ST_START);
    wdt_cov_c: cover property (st_r == ST_RUN && wdt_evt ##1 st_r == ST_START);
endmodule

/* File: include/rss_pkg.sv */
// Purpose: Shared constants and types of the reset source sequencer.
// Assumes: Device clock of 100 MHz; 8-bit register port with 4-bit address.
// Notes: Times are kept in their own unit and turned into cycle counts here.
package rss_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // Power-up delay, nominal 64 ms.
    localparam int unsigned POWERUP_DELAY_TIMER_TIME_MS = 64;
    localparam int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_TIME_MS * 1000 * CLK_MHZ;
    // Brown-out dip filter; least time, rounded up.
    localparam int unsigned BOR_FILTER_NS = 1000;
    localparam int unsigned BOR_FILTER_CYCLES = (BOR_FILTER_NS * CLK_MHZ + 999) / 1000;
    // Reset pin low-pulse filter; least time, rounded up.
    localparam int unsigned PIN_FILTER_NS = 200;
    localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;
    // Clock cycles from reset pin release to execution.
    localparam int unsigned EXEC_DELAY_CYCLES = 10;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [3:0] REG_BROWNOUT_CONTROL = 4'h0;
    localparam logic [3:0] REG_POWER_CONTROL_REG = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_PINCTL = 4'h3;

    localparam int unsigned BROWNOUT_CONTROL_SBOR_BIT = 7;
    localparam int unsigned BROWNOUT_CONTROL_FS_BIT = 6;
    localparam int unsigned BROWNOUT_CONTROL_RDY_BIT = 0;
    localparam logic BROWNOUT_CONTROL_SBOR_RST = 1'b1;
    localparam logic BROWNOUT_CONTROL_FS_RST = 1'b0;

    localparam int unsigned POWER_CONTROL_REG_OVF_BIT = 7;
    localparam int unsigned POWER_CONTROL_REG_UNF_BIT = 6;
    localparam int unsigned POWER_CONTROL_REG_WDT_BIT = 4;
    localparam int unsigned POWER_CONTROL_REG_PIN_BIT = 3;
    localparam int unsigned POWER_CONTROL_REG_RI_BIT = 2;
    localparam int unsigned POWER_CONTROL_REG_POR_BIT = 1;
    localparam int unsigned POWER_CONTROL_REG_BOR_BIT = 0;
    localparam logic [7:0] POWER_CONTROL_REG_POR_VAL = 8'h1c;
    localparam logic [7:0] POWER_CONTROL_REG_IMPL_MASK = 8'hdf;

    localparam int unsigned STATUS_TO_BIT = 4;
    localparam int unsigned STATUS_PD_BIT = 3;
    localparam int unsigned PINCTL_PULLUP_BIT = 0;
    localparam int unsigned PINCTL_LEVEL_BIT = 1;
    localparam logic PINCTL_PULLUP_RST = 1'b0;

    localparam logic [1:0] BOR_ALWAYS_ON = 2'b11;
    localparam logic [1:0] BOR_NO_SLEEP = 2'b10;
    localparam logic [1:0] BOR_SOFTWARE = 2'b01;
    localparam logic [1:0] BOR_ALWAYS_OFF = 2'b00;

    typedef enum logic [2:0] {ST_HOLD, ST_POWERUP_DELAY_TIMER, ST_START, ST_EXEC, ST_RUN} rss_state_t;
endpackage

/* File: verification/rss_supply_model.sv */
// Purpose: Brown-out monitor readiness and reset pin as seen by the sequencer.
// Assumes: The testbench commands pin pulls; supply levels come from the testbench.
// Notes: An undriven pin without pull-up toggles, so a stale level never passes.
module rss_supply_model #(
    parameter int READY_DLY = 4
) (
    input wire logic clock_i,
    input wire logic monitor_en_i,
    input wire logic pullup_en_i,
    input wire logic pin_out_i,
    input wire logic pin_oe_n_i,
    input wire logic pull_low_i,
    output logic bor_ready_o,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int warm = 0;
    logic flip = 1'b0;
    // The monitor needs some cycles of being enabled before it reports ready.
    always @(posedge clock_i) begin
        warm <= monitor_en_i ? warm + 1 : 0;
        flip <= ~flip;
    end
    assign bor_ready_o = (warm >= READY_DLY);
    assign pin_o = ((!pin_oe_n_i && !pin_out_i) || pull_low_i) ? 1'b0 : (pullup_en_i ? 1'b1 : flip);
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench of the reset source sequencer.
// Assumes: Shortened power-up, brown-out and pin filter counts.
// Notes: Expected timings are loose windows around the documented sequence.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import rss_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, rv;
    logic wr = 1'b0, rd = 1'b0, sleep = 1'b0, osc = 1'b1, por = 1'b1;
    logic [1:0] mode = 2'b00;
    logic powerup_delay_timer_n = 1'b0, ext_reset_pin_enable = 1'b1, low_voltage_prog_enable = 1'b0, lpdis = 1'b1, stk_en = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic [5:0] ev = 6'h00;
    logic core_rst, hold, mon_en, bg, pu, pout, poe_n, plev, rdy, pin;
    logic [7:0] tbl [7] = '{8'hcc, 8'hec, 8'h8e, 8'haa, 8'h54, 8'h4a, 8'h18};
    int n_fail = 0, total_checks = 0, cyc;
    always #5 clock_i = ~clock_i;
    rss_reset_sequencer #(.POWERUP_DELAY_TIMER_CYC(20), .BOR_FLT_CYC(3), .PIN_FLT_CYC(2)) dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .brownout_mode_sel_i(mode),
        .powerup_delay_disable_n_i(powerup_delay_timer_n), .ext_reset_pin_enable_i(ext_reset_pin_enable),
        .low_voltage_prog_enable_i(low_voltage_prog_enable), .lowpower_brownout_disable_i(lpdis),
        .stack_fault_reset_enable_i(stk_en), .por_active_i(por), .bor_below_i(lvl[0]),
        .bor_ready_i(rdy), .lowpower_brownout_below_i(lvl[1]), .osc_ready_i(osc),
        .external_reset_pin_i(pin), .sleep_i(sleep), .watchdog_timeout_i(ev[0]),
        .watchdog_clear_instr_i(ev[1]), .reset_instr_i(ev[2]), .stack_over_i(ev[3]),
        .stack_under_i(ev[4]), .prog_exit_i(ev[5]), .core_reset_o(core_rst),
        .wake_hold_o(hold), .bor_monitor_en_o(mon_en), .bandgap_force_o(bg),
        .pin_pullup_en_o(pu), .pin_out_o(pout), .pin_oe_n_o(poe_n), .pin_gpio_level_o(plev));
    rss_supply_model model (.clock_i(clock_i), .monitor_en_i(mon_en), .pullup_en_i(pu),
        .pin_out_i(pout), .pin_oe_n_i(poe_n), .pull_low_i(lvl[2]), .bor_ready_o(rdy),
        .pin_o(pin));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        // Read data stand only in the cycle after the strobe; take them once settled.
        #1;
        rv = rdata;
    endtask
    task automatic pulse(input int i);
        @(posedge clock_i);
        ev[i] <= 1'b1;
        @(posedge clock_i);
        ev[i] <= 1'b0;
    endtask
    task automatic lower(input int i, input int n);
        @(posedge clock_i);
        lvl[i] <= 1'b1;
        tick(n);
        lvl[i] <= 1'b0;
        tick(3);
    endtask
    task automatic wait_run(input int hi);
        cyc = 0;
        // Let the edge that launched the reset settle before looking at it.
        #1;
        while (core_rst !== 1'b0 && cyc < hi) begin
            @(posedge clock_i);
            #1;
            cyc++;
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        give_verdict();
    end
    initial begin
        tick(20);
        reset_n_i <= 1'b1;
        tick(3);
        por <= 1'b0;
        wait_run(80);
        check(8'(cyc >= 30 && cyc < 45), 8'h01);
        rreg(REG_BROWNOUT_CONTROL);
        check(rv, 8'h80);
        wreg(REG_BROWNOUT_CONTROL, 8'h41);
        rreg(REG_BROWNOUT_CONTROL);
        check(rv, 8'h40);
        rreg(4'h9);
        check(rv, 8'h00);
        powerup_delay_timer_n <= 1'b1;
        pulse(5);
        wait_run(80);
        check(8'(cyc >= 8 && cyc < 25), 8'h01);
        powerup_delay_timer_n <= 1'b0;
        pulse(5);
        wait_run(80);
        check(8'(cyc >= 28 && cyc < 45), 8'h01);
        rreg(REG_POWER_CONTROL_REG);
        check(rv, 8'h1c);
        for (int i = 0; i < 7; i++) begin
            mode <= tbl[i][7:6];
            sleep <= tbl[i][5];
            wreg(REG_BROWNOUT_CONTROL, {tbl[i][4:3], 6'h00});
            tick(3);
            check({6'h00, mon_en, bg}, {6'h00, tbl[i][2:1]});
        end
        mode <= 2'b10;
        sleep <= 1'b1;
        tick(10);
        sleep <= 1'b0;
        tick(2);
        check({7'h00, hold}, 8'h01);
        tick(20);
        check({7'h00, hold}, 8'h00);
        mode <= 2'b11;
        sleep <= 1'b1;
        tick(10);
        sleep <= 1'b0;
        tick(2);
        check({7'h00, hold}, 8'h00);
        tick(10);
        rreg(REG_BROWNOUT_CONTROL);
        check(rv & 8'h01, 8'h01);
        lower(0, 2);
        tick(5);
        check({7'h00, core_rst}, 8'h00);
        lower(0, 10);
        check({7'h00, core_rst}, 8'h01);
        wait_run(100);
        rreg(REG_POWER_CONTROL_REG);
        check(rv & 8'h01, 8'h00);
        wreg(REG_POWER_CONTROL_REG, 8'hff);
        lpdis <= 1'b0;
        lower(1, 10);
        check({7'h00, core_rst}, 8'h01);
        wait_run(100);
        rreg(REG_POWER_CONTROL_REG);
        check(rv & 8'h01, 8'h00);
        lpdis <= 1'b1;
        lower(1, 10);
        check({7'h00, core_rst}, 8'h00);
        pulse(2);
        tick(2);
        check({7'h00, core_rst}, 8'h01);
        wait_run(60);
        rreg(REG_POWER_CONTROL_REG);
        check(rv & 8'h04, 8'h00);
        pulse(0);
        tick(2);
        check({7'h00, core_rst}, 8'h01);
        wait_run(60);
        rreg(REG_STATUS);
        check(rv & 8'h10, 8'h00);
        rreg(REG_POWER_CONTROL_REG);
        check(rv & 8'h10, 8'h00);
        pulse(1);
        rreg(REG_STATUS);
        check(rv & 8'h18, 8'h18);
        pulse(3);
        tick(2);
        check({7'h00, core_rst}, 8'h00);
        stk_en <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wreg(REG_POWER_CONTROL_REG, 8'h3f);
            pulse(3 + i);
            tick(2);
            check({7'h00, core_rst}, 8'h01);
            wait_run(60);
            rreg(REG_POWER_CONTROL_REG);
            check(rv & 8'hc0, 8'h80 >> i);
        end
        check({6'h00, pu, poe_n}, 8'h03);
        lower(2, 1);
        check({7'h00, core_rst}, 8'h00);
        lower(2, 40);
        wait_run(60);
        check(8'(cyc >= 8 && cyc < 20), 8'h01);
        check({6'h00, pout, poe_n}, 8'h03);
        ext_reset_pin_enable <= 1'b0;
        low_voltage_prog_enable <= 1'b1;
        lower(2, 10);
        check({7'h00, core_rst}, 8'h01);
        wait_run(60);
        low_voltage_prog_enable <= 1'b0;
        wreg(REG_PINCTL, 8'h01);
        tick(2);
        check({7'h00, pu}, 8'h01);
        lower(2, 10);
        check({7'h00, core_rst}, 8'h00);
        lvl[2] <= 1'b1;
        tick(5);
        check({7'h00, plev}, 8'h00);
        lvl[2] <= 1'b0;
        wreg(REG_PINCTL, 8'h00);
        tick(2);
        check({7'h00, pu}, 8'h00);
        give_verdict();
    end
endmodule
